// file: pkg/tcst_params.svh
// Overview of operation
// - Three independent counter channels 0..2, each with its own gate and output, all sharing one count clock.
// - Every channel counts down on the common 1.190 MHz board oscillator clock, not the bus clock.
// - The gate of channel 2 follows bit 0 of the peripheral control port at I/O address 61h.
// - The output of channel 2, ANDed with bit 1 of port 61h, drives the speaker, so the programmed count sets the tone.
// - The timer answers at five I/O ports, 40h-43h and 61h, three giving read/write access to counters 0..2.
// - The fourth port is a write-only control word selecting the mode of the addressed channel.
`ifndef TCST_PARAMS_SVH
`define TCST_PARAMS_SVH

// ---------------------------------------------
// i/o map
// ---------------------------------------------
`define TCST_IO_CNT0      10'h040
`define TCST_IO_CNT1      10'h041
`define TCST_IO_CNT2      10'h042
`define TCST_IO_CTRL      10'h043
`define TCST_IO_PCTL      10'h061

// ---------------------------------------------
// control word fields
// ---------------------------------------------
`define TCST_CW_SEL_HI    7
`define TCST_CW_SEL_LO    6
`define TCST_CW_RW_HI     5
`define TCST_CW_RW_LO     4
`define TCST_CW_MODE_HI   3
`define TCST_CW_MODE_LO   1
`define TCST_PCTL_GATE2   0
`define TCST_PCTL_SPKEN   1

// ---------------------------------------------
// reset values and timing
// ---------------------------------------------
`define TCST_RST_PCTL     8'h00
`define TCST_RST_RELOAD   16'h0000
`define TCST_REFRESH_NS   15000
`define TCST_OSC_KHZ      1190

`endif

// file: pkg/tcst_pkg.sv
package tcst_pkg;
    typedef enum logic [1:0] {
        TCST_RW_LATCH,
        TCST_RW_LSB,
        TCST_RW_MSB,
        TCST_RW_BOTH
    } tcst_rw_e;
    typedef logic [15:0] tcst_count_t;
    typedef logic [2:0]  tcst_mode_t;
endpackage

// file: hdl/tcst_channel.sv
`timescale 1ns/1ns
`default_nettype none
`include "tcst_params.svh"
module tcst_channel
    import tcst_pkg::*;
(
    // clock and reset
    input  wire logic        core_clk,
    input  wire logic        resetn,
    // count clock and gate
    input  wire logic        tick,
    input  wire logic        gate,
    // programming
    input  wire logic        load,
    input  wire tcst_count_t load_val,
    input  wire tcst_mode_t  mode,
    // result
    output tcst_count_t      count,
    output logic             out
);
    tcst_count_t next_count;
    logic        next_out;
    logic        armed;
    logic        next_armed;
    logic        square;

    // ---------------------------------------------
    // count down on oscillator tick
    // ---------------------------------------------
    always_comb begin
        square     = mode[1];
        next_count = count;
        next_out   = out;
        next_armed = armed;
        if (load) begin
            next_count = load_val;
            next_armed = 1'b1;
            next_out   = 1'b1;
        end else if (tick && gate && armed) begin
            if (count <= 16'h0002 && count != 16'h0000) begin
                next_count = load_val;
                next_out   = square ? ~out : 1'b0;
            end else begin
                next_count = count - 16'h0001;
                if (!square) next_out = 1'b1;
            end
        end else if (!gate && square) begin
            next_out = 1'b1;
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            count <= `TCST_RST_RELOAD;
            out   <= 1'b1;
            armed <= 1'b0;
        end else begin
            count <= next_count;
            out   <= next_out;
            armed <= next_armed;
        end
    end

    chk_load_rearm: assert property (@(posedge core_clk) disable iff (!resetn)
        load |=> (count == $past(load_val) && out))
        else $error("channel did not take new count");
endmodule
`default_nettype wire

// file: hdl/tcst_timer.sv
`timescale 1ns/1ns
`default_nettype none
`include "tcst_params.svh"
module tcst_timer
    import tcst_pkg::*;
(
    // clock and reset
    input  wire logic       core_clk,
    input  wire logic       resetn,
    // board oscillator
    input  wire logic       board_oscillator_clock,
    // i/o port access
    input  wire logic [9:0] io_addr,
    input  wire logic       io_wr,
    input  wire logic       io_rd,
    input  wire logic [7:0] io_wdata,
    output logic      [7:0] io_rdata,
    output logic            io_hit,
    // channel outputs
    output logic            irq0,
    output logic            refresh_req,
    output logic            speaker
);
    logic        osc_s1;
    logic        osc_s2;
    logic        osc_d;
    logic        tick;
    logic [7:0]  pctl;
    logic [7:0]  next_pctl;
    tcst_count_t reload [3];
    tcst_count_t next_reload [3];
    tcst_rw_e    rwsel [3];
    tcst_rw_e    next_rwsel [3];
    tcst_mode_t  mode [3];
    tcst_mode_t  next_mode [3];
    logic [2:0]  flip;
    logic [2:0]  next_flip;
    logic [2:0]  load;
    logic [2:0]  next_load;
    tcst_count_t cnt [3];
    tcst_count_t latch [3];
    tcst_count_t next_latch [3];
    logic [2:0]  latched;
    logic [2:0]  next_latched;
    logic [2:0]  rflip;
    logic [2:0]  next_rflip;
    logic [2:0]  ch_out;
    logic [2:0]  gate;
    logic [7:0]  next_rdata;
    logic        next_hit;
    logic [1:0]  sel;
    logic [1:0]  cw_sel;
    logic        cnt_port;

    // ---------------------------------------------
    // oscillator synchroniser and edge
    // ---------------------------------------------
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            osc_s1 <= 1'b0;
            osc_s2 <= 1'b0;
            osc_d  <= 1'b0;
        end else begin
            osc_s1 <= board_oscillator_clock;
            osc_s2 <= osc_s1;
            osc_d  <= osc_s2;
        end
    end
    assign tick = osc_s2 & ~osc_d;

    // ---------------------------------------------
    // port decode and programming
    // ---------------------------------------------
    assign cnt_port = (io_addr >= `TCST_IO_CNT0) && (io_addr <= `TCST_IO_CNT2);
    assign sel      = io_addr[1:0];
    assign cw_sel   = io_wdata[`TCST_CW_SEL_HI:`TCST_CW_SEL_LO];

    always_comb begin
        next_pctl    = pctl;
        next_reload  = reload;
        next_rwsel   = rwsel;
        next_mode    = mode;
        next_flip    = flip;
        next_load    = 3'b000;
        next_latch   = latch;
        next_latched = latched;
        next_rflip   = rflip;
        next_rdata   = io_rdata;
        next_hit     = 1'b0;
        if (io_wr && io_addr == `TCST_IO_PCTL) begin
            next_pctl = io_wdata;
        end else if (io_wr && io_addr == `TCST_IO_CTRL) begin
            if (cw_sel != 2'b11 && io_wdata[`TCST_CW_RW_HI:`TCST_CW_RW_LO] == 2'b00) begin
                next_latch[cw_sel]   = cnt[cw_sel];
                next_latched[cw_sel] = 1'b1;
            end else if (cw_sel != 2'b11) begin
                next_rwsel[cw_sel] = tcst_rw_e'(io_wdata[`TCST_CW_RW_HI:`TCST_CW_RW_LO]);
                next_mode[cw_sel]  = io_wdata[`TCST_CW_MODE_HI:`TCST_CW_MODE_LO];
                next_flip[cw_sel]  = 1'b0;
                next_rflip[cw_sel] = 1'b0;
            end
        end else if (io_wr && cnt_port) begin
            case (rwsel[sel])
                TCST_RW_LSB: begin
                    next_reload[sel] = {8'h00, io_wdata};
                    next_load[sel]   = 1'b1;
                end
                TCST_RW_MSB: begin
                    next_reload[sel] = {io_wdata, 8'h00};
                    next_load[sel]   = 1'b1;
                end
                TCST_RW_BOTH: begin
                    if (!flip[sel]) begin
                        next_reload[sel][7:0] = io_wdata;
                    end else begin
                        next_reload[sel][15:8] = io_wdata;
                        next_load[sel]         = 1'b1;
                    end
                    next_flip[sel] = ~flip[sel];
                end
                default: begin
                end
            endcase
        end
        if (io_rd && cnt_port) begin
            next_hit = 1'b1;
            case (rwsel[sel])
                TCST_RW_LSB: next_rdata = latched[sel] ? latch[sel][7:0] : cnt[sel][7:0];
                TCST_RW_MSB: next_rdata = latched[sel] ? latch[sel][15:8] : cnt[sel][15:8];
                default: begin
                    if (!rflip[sel]) begin
                        next_rdata = latched[sel] ? latch[sel][7:0] : cnt[sel][7:0];
                    end else begin
                        next_rdata = latched[sel] ? latch[sel][15:8] : cnt[sel][15:8];
                        next_latched[sel] = 1'b0;
                    end
                    next_rflip[sel] = ~rflip[sel];
                end
            endcase
        end else if (io_rd && io_addr == `TCST_IO_PCTL) begin
            next_hit   = 1'b1;
            next_rdata = {2'b00, ch_out[2], 3'b000, pctl[1:0]};
        end else if (io_rd) begin
            next_hit   = io_addr == `TCST_IO_CTRL;
            next_rdata = 8'h00;
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            pctl     <= `TCST_RST_PCTL;
            reload   <= '{default: `TCST_RST_RELOAD};
            rwsel    <= '{default: TCST_RW_BOTH};
            mode     <= '{default: 3'h0};
            flip     <= 3'b000;
            load     <= 3'b000;
            latch    <= '{default: `TCST_RST_RELOAD};
            latched  <= 3'b000;
            rflip    <= 3'b000;
            io_rdata <= 8'h00;
            io_hit   <= 1'b0;
        end else begin
            pctl     <= next_pctl;
            reload   <= next_reload;
            rwsel    <= next_rwsel;
            mode     <= next_mode;
            flip     <= next_flip;
            load     <= next_load;
            latch    <= next_latch;
            latched  <= next_latched;
            rflip    <= next_rflip;
            io_rdata <= next_rdata;
            io_hit   <= next_hit;
        end
    end

    // ---------------------------------------------
    // channels
    // ---------------------------------------------
    assign gate = {pctl[`TCST_PCTL_GATE2], 1'b1, 1'b1};

    generate
        for (genvar i = 0; i < 3; i++) begin : g_ch
            tcst_channel u_ch (
                .core_clk (core_clk),
                .resetn   (resetn),
                .tick     (tick),
                .gate     (gate[i]),
                .load     (load[i]),
                .load_val (reload[i]),
                .mode     (mode[i]),
                .count    (cnt[i]),
                .out      (ch_out[i])
            );
        end
    endgenerate

    assign irq0        = ch_out[0];
    assign refresh_req = ch_out[1];
    assign speaker     = ch_out[2] & pctl[`TCST_PCTL_SPKEN];

    // ---------------------------------------------
    // checks
    // ---------------------------------------------
    chk_gate_follow: assert property (@(posedge core_clk) disable iff (!resetn)
        (io_wr && io_addr == `TCST_IO_PCTL) |=> gate[2] == $past(io_wdata[0]))
        else $error("gate 2 not following port bit 0");
    chk_spk_route: assert property (@(posedge core_clk) disable iff (!resetn)
        speaker == (ch_out[2] && pctl[1]))
        else $error("speaker not driven by channel 2");
    chk_cnt_write: assert property (@(posedge core_clk) disable iff (!resetn)
        (io_wr && cnt_port && rwsel[sel] == TCST_RW_LSB) |=> ##1 cnt[$past(sel,2)] ==
        {8'h00, $past(io_wdata, 2)})
        else $error("counter write not loaded");
    chk_ctrl_mode: assert property (@(posedge core_clk) disable iff (!resetn)
        (io_wr && io_addr == `TCST_IO_CTRL && io_wdata[7:6] == 2'b00 && io_wdata[5:4] != 2'b00)
        |=> mode[0] == $past(io_wdata[3:1]))
        else $error("control word mode not taken");
    chk_ctrl_wo: assert property (@(posedge core_clk) disable iff (!resetn)
        (io_rd && io_addr == `TCST_IO_CTRL) |=> io_rdata == 8'h00)
        else $error("control port is not write only");
    chk_gate_tied: assert property (@(posedge core_clk) disable iff (!resetn)
        gate[1:0] == 2'b11)
        else $error("gates 0 and 1 not active");
    chk_no_tick_hold: assert property (@(posedge core_clk) disable iff (!resetn)
        (!tick && !load[0]) |=> cnt[0] == $past(cnt[0]))
        else $error("channel 0 counted without oscillator edge");
    chk_irq_route: assert property (@(posedge core_clk) disable iff (!resetn)
        irq0 == ch_out[0] && refresh_req == ch_out[1])
        else $error("channel outputs misrouted");
    cov_tone: cover property (@(posedge core_clk) disable iff (!resetn) $rose(speaker));
    cov_irq: cover property (@(posedge core_clk) disable iff (!resetn) $fell(irq0));
    cov_latch: cover property (@(posedge core_clk) disable iff (!resetn) |latched);
endmodule
`default_nettype wire

// file: verification/tcst_host_model.sv
`timescale 1ns/1ns
`default_nettype none
`include "tcst_params.svh"
module tcst_host_model (
    // clock
    input  wire logic       core_clk,
    // i/o port access
    output logic      [9:0] io_addr,
    output logic            io_wr,
    output logic            io_rd,
    output logic      [7:0] io_wdata,
    input  wire logic [7:0] io_rdata,
    input  wire logic       io_hit
);
    initial begin
        io_addr  = 10'h000;
        io_wr    = 1'b0;
        io_rd    = 1'b0;
        io_wdata = 8'h00;
    end

    // ---------------------------------------------
    // port cycles, one strobe cycle each
    // ---------------------------------------------
    task automatic wr(input logic [9:0] a, input logic [7:0] d);
        @(negedge core_clk);
        io_addr  = a;
        io_wdata = d;
        io_wr    = 1'b1;
        @(negedge core_clk);
        io_wr    = 1'b0;
        io_wdata = ~d;
    endtask

    task automatic rd(input logic [9:0] a, output logic [7:0] d, output logic h);
        @(negedge core_clk);
        io_addr = a;
        io_rd   = 1'b1;
        @(negedge core_clk);
        d       = io_rdata;
        h       = io_hit;
        io_rd   = 1'b0;
    endtask

    // refresh pacing: output toggles every reload-1 ticks, reload 10 gives a period of 18 ticks
    task automatic refresh_setup();
        wr(`TCST_IO_CTRL, 8'h74);
        wr(`TCST_IO_CNT1, 8'h0a);
        wr(`TCST_IO_CNT1, 8'h00);
    endtask
endmodule
`default_nettype wire

// file: verification/tcst_timer_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
`include "tcst_params.svh"
`define CHK(got, exp, msg) begin total_checks++; if ((got) !== (exp)) begin \
    fail_count++; $display("CHECK FAILED at %0t: %s", $time, msg); end end
module tcst_timer_tb_top;
    logic       core_clk = 1'b0;
    logic       resetn = 1'b0;
    logic       board_oscillator_clock = 1'b0;
    logic       osc_run = 1'b1;
    logic [3:0] osc_div = 4'h0;
    logic [9:0] io_addr;
    logic       io_wr;
    logic       io_rd;
    logic [7:0] io_wdata;
    logic [7:0] io_rdata;
    logic       io_hit;
    logic       irq0;
    logic       refresh_req;
    logic       speaker;
    int         fail_count = 0;
    int         total_checks = 0;

    tcst_timer i_dut (.core_clk(core_clk), .resetn(resetn),
        .board_oscillator_clock(board_oscillator_clock), .io_addr(io_addr), .io_wr(io_wr),
        .io_rd(io_rd), .io_wdata(io_wdata), .io_rdata(io_rdata), .io_hit(io_hit),
        .irq0(irq0), .refresh_req(refresh_req), .speaker(speaker));
    tcst_host_model i_host (.core_clk(core_clk), .io_addr(io_addr), .io_wr(io_wr),
        .io_rd(io_rd), .io_wdata(io_wdata), .io_rdata(io_rdata), .io_hit(io_hit));

    // ---------------------------------------------
    // clocks: core 50 ns, board clock 16 core cycles
    // ---------------------------------------------
    always #25 core_clk = ~core_clk;
    always @(negedge core_clk) begin
        if (osc_run) begin
            osc_div <= osc_div + 4'h1;
            if (osc_div == 4'h7) begin
                osc_div                <= 4'h0;
                board_oscillator_clock <= ~board_oscillator_clock;
            end
        end
    end

    // ---------------------------------------------
    // helpers
    // ---------------------------------------------
    task automatic end_of_test();
        $display("checks %0d, mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic wait_out(input int idx, input logic v, input int n);
        logic [2:0] o;
        for (int i = 0; i < n; i++) begin
            @(negedge core_clk);
            o = {speaker, refresh_req, irq0};
            if (o[idx] === v) return;
        end
        fail_count++;
        $display("CHECK FAILED at %0t: output wait timed out", $time);
        end_of_test();
    endtask

    task automatic read_count(input logic [1:0] ch, output logic [15:0] v);
        logic h;
        i_host.wr(`TCST_IO_CTRL, {ch, 6'h00});
        i_host.rd(`TCST_IO_CNT0 + {8'h00, ch}, v[7:0], h);
        i_host.rd(`TCST_IO_CNT0 + {8'h00, ch}, v[15:8], h);
    endtask

    // ---------------------------------------------
    // scenarios
    // ---------------------------------------------
    task automatic t_ports();
        logic [7:0] d;
        logic       h;
        i_host.rd(`TCST_IO_PCTL, d, h);
        `CHK({h, d}, 9'h120, "port 61h after reset")
        i_host.rd(`TCST_IO_CTRL, d, h);
        `CHK({h, d}, 9'h100, "control port reads 00")
        i_host.rd(10'h044, d, h);
        `CHK(h, 1'b0, "unmapped port answered")
        i_host.rd(`TCST_IO_CNT2, d, h);
        `CHK(h, 1'b1, "counter port not answered")
    endtask

    task automatic t_chan0();
        logic [15:0] a;
        logic [15:0] b;
        i_host.wr(`TCST_IO_CTRL, 8'h34);
        i_host.wr(`TCST_IO_CNT0, 8'h0a);
        i_host.wr(`TCST_IO_CNT0, 8'h00);
        wait_out(0, 1'b0, 400);
        read_count(2'd0, a);
        `CHK(a > 16'h0000 && a < 16'h000b, 1'b1, "ch0 count out of range")
        osc_run = 1'b0;
        repeat (4) @(negedge core_clk);
        read_count(2'd0, a);
        repeat (100) @(negedge core_clk);
        read_count(2'd0, b);
        `CHK(b, a, "count moved with board clock stopped")
        osc_run = 1'b1;
        repeat (40) @(negedge core_clk);
        read_count(2'd0, b);
        `CHK(b !== a, 1'b1, "count frozen with board clock running")
    endtask

    task automatic t_refresh();
        int n;
        i_host.refresh_setup();
        wait_out(1, 1'b0, 600);
        wait_out(1, 1'b1, 300);
        n = 0;
        while (refresh_req !== 1'b0 && n < 600) begin
            @(negedge core_clk);
            n++;
        end
        while (refresh_req !== 1'b1 && n < 600) begin
            @(negedge core_clk);
            n++;
        end
        `CHK(n >= 17 * 16 && n <= 19 * 16, 1'b1, "refresh period not 18 ticks")
        wait_out(0, 1'b0, 400);
    endtask

    task automatic t_speaker();
        logic [15:0] a;
        logic [15:0] b;
        logic [7:0]  d;
        logic        h;
        i_host.wr(`TCST_IO_PCTL, 8'h02);
        i_host.wr(`TCST_IO_CTRL, 8'hb6);
        i_host.wr(`TCST_IO_CNT2, 8'h04);
        i_host.wr(`TCST_IO_CNT2, 8'h00);
        repeat (20) @(negedge core_clk);
        read_count(2'd2, a);
        repeat (100) @(negedge core_clk);
        read_count(2'd2, b);
        `CHK(b, a, "ch2 counted with gate low")
        i_host.wr(`TCST_IO_PCTL, 8'h03);
        wait_out(2, 1'b0, 200);
        wait_out(2, 1'b1, 200);
        wait_out(2, 1'b0, 200);
        i_host.rd(`TCST_IO_PCTL, d, h);
        `CHK(d[1:0], 2'b11, "port 61h readback")
        i_host.wr(`TCST_IO_PCTL, 8'h01);
        repeat (40) @(negedge core_clk);
        `CHK(speaker, 1'b0, "speaker on while disabled")
    endtask

    task automatic t_bytes();
        logic [7:0] d;
        logic       h;
        osc_run = 1'b0;
        repeat (4) @(negedge core_clk);
        i_host.wr(`TCST_IO_CTRL, 8'h10);
        i_host.wr(`TCST_IO_CNT0, 8'h05);
        repeat (2) @(negedge core_clk);
        i_host.rd(`TCST_IO_CNT0, d, h);
        `CHK({h, d}, 9'h105, "low byte only access")
        i_host.wr(`TCST_IO_CTRL, 8'h20);
        i_host.wr(`TCST_IO_CNT0, 8'h03);
        repeat (2) @(negedge core_clk);
        i_host.rd(`TCST_IO_CNT0, d, h);
        `CHK({h, d}, 9'h103, "high byte only access")
    endtask

    // ---------------------------------------------
    // main sequence
    // ---------------------------------------------
    initial begin
        repeat (4) @(posedge core_clk);
        @(negedge core_clk);
        `CHK({irq0, refresh_req, speaker}, 3'b110, "outputs in reset")
        resetn = 1'b1;
        t_ports();
        t_chan0();
        t_refresh();
        t_speaker();
        t_bytes();
        end_of_test();
    end
endmodule
`default_nettype wire
